// ==== ion_spectrometer_sequencer_tb.sv ====
/* Bench for the sequencer: APB master, pulse source, readout.
   Assumes the sync model and a shortened calibration period. */
`timescale 1ns/1ps
module ion_spectrometer_sequencer_tb;
    import isq_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, tm_load, tm_shift;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        pready, pslverr, rd_e, minor_sync, major_sync, cs;
    logic [2:0]  head_pulse = 3'h0; // All heads pulse together
    logic [2:0]  tm_data, lmsk;
    logic [3:0]  tmsk;
    logic [31:0] tmv;
    isq_ref_t    ref_out;
    isq_det_t    det_out;
    logic [1:0]  primary_head;
    isq_status_t status;
    int n_fail = 0, total_checks = 0, nmaj = 0, cnt = 0, pm = 0;
    logic [4:0] mass_tab [4] = '{MASS_OXY, MASS_HEL, MASS_HYD, 5'h05};
    logic [1:0] head_tab [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    logic [1:0] lv_tab [3] = '{HV_RAISED, HV_LOWERED, HV_NOMINAL};

    isq_sequencer #(.CAL_PERIOD(4)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .minor_sync(minor_sync), .major_sync(major_sync),
        .head_pulse(head_pulse), .tm_load(tm_load), .tm_shift(tm_shift),
        .tm_data(tm_data), .ref_out(ref_out), .det_out(det_out),
        .primary_head(primary_head), .status(status));
    isq_sync_model sync_u (.pclk(pclk), .presetn(presetn),
        .minor_sync(minor_sync), .major_sync(major_sync));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Three pulses early in each step; only step 0 feeds the secondaries
    always @(posedge pclk) begin
        cnt <= minor_sync ? 0 : cnt + 1;
        head_pulse <= (cnt >= 1 && cnt <= 3) ? 3'h7 : 3'h0;
        if (major_sync === 1'b1) nmaj <= nmaj + 1;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task summarize();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // Request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd_v = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin n_fail++; summarize(); end
    endtask : apb
    // Bounded wait for a sync pulse seen at an edge
    task wait_ev(input logic maj);
        int n;
        n = 0;
        do begin @(posedge pclk); n++; end
        while ((maj ? major_sync : minor_sync) !== 1'b1 && n < 400);
        if ((maj ? major_sync : minor_sync) !== 1'b1) begin n_fail++; summarize(); end
    endtask : wait_ev
    // Load, then one shift per bit; each bit shows two edges later
    task read_tm();
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            tm_load  <= (i == 0);
            tm_shift <= (i != 0);
            @(posedge pclk);
            tm_load  <= 1'b0;
            tm_shift <= 1'b0;
            @(posedge pclk);
            @(negedge pclk);
            tmv = {tmv[29:0], tm_data[1:0]};
        end
    endtask : read_tm
    task at_slot(input int steps);
        wait_ev(1'b1);
        repeat (steps) wait_ev(1'b0);
        repeat (3) @(posedge pclk);
    endtask : at_slot
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, tm_load, tm_shift, presetn} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd_v, 32'(CTRL_RESET));
        chk("hv_on", 32'(det_out.hv_on), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("err", 32'(rd_e), 32'h1);
        chk("udata", rd_v, 32'h0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_CTRL, 32'(m));
            chk("hold", 32'(status.active_mode), 32'(pm));
            at_slot(5);
            chk("mode", 32'(status.active_mode), 32'(m));
            chk("echo", 32'(status.cmd_echo), 32'(m));
            chk("rstep", 32'(ref_out.retard_step), (m == 3) ? 32'h0 : 32'h5);
            chk("mass", 32'(ref_out.mass_code), 32'(mass_tab[m]));
            chk("head", 32'(primary_head), 32'(head_tab[nmaj % 4]));
            chk("hv_off", 32'(det_out.hv_on), 32'h0);
            for (int i = 0; i < 3; i++) begin
                apb(1'b0, ADDR_PRIM + 8'(4 * i), 32'h0);
                chk("count", rd_v, 32'h3);
            end
            pm = m;
        end
        read_tm();
        chk("serial", tmv, 32'hf);
        $display("test modes done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h8 | (32'(lv_tab[i]) << CTRL_HV_LSB));
            at_slot(0);
            chk("level", 32'(det_out.hv_level), 32'(lv_tab[i]));
            chk("hv_en", 32'(det_out.hv_on), 32'h1);
        end
        $display("test level done");
        apb(1'b1, ADDR_CTRL, 32'hc);
        wait_ev(1'b1);
        {tmsk, lmsk} = 7'h00;
        repeat (8) begin
            at_slot(0);
            tmsk |= 4'h1 << det_out.threshold;
            lmsk |= 3'h1 << det_out.hv_level;
            chk("calmass", 32'(ref_out.mass_code), 32'(MASS_OXY));
        end
        chk("thr", 32'(tmsk), 32'hf);
        chk("lvl", 32'(lmsk), 32'h6);
        $display("test calibrate done");
        apb(1'b1, ADDR_CTRL, 32'hf);
        at_slot(0);
        chk("auto", 32'(status.active_mode), 32'(MODE_AUTO));
        chk("base0", 32'(status.base_mode), 32'h0);
        cs = 1'b0;
        repeat (32) begin
            at_slot(0);
            cs |= status.cal_active;
        end
        chk("base1", 32'(status.base_mode), 32'h1);
        chk("amass", 32'(ref_out.mass_code), 32'(MASS_HEL));
        chk("autocal", 32'(cs), 32'h1);
        $display("test auto done");
        summarize();
    end
endmodule : ion_spectrometer_sequencer_tb

// ==== isq_accum.sv ====
/*
 * One pulse accumulator with its snapshot and telemetry shift register.
 * Assumes pulses, sample and shift strobes are one-cycle, synchronous
 * to pclk.
 */
`timescale 1ns/1ps
module isq_accum
    import isq_pkg::*;
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Counting
    input  wire logic             pulse,
    input  wire logic             enable,
    input  wire logic             sample,
    // Telemetry readout
    input  wire logic             tm_load,
    input  wire logic             tm_shift,
    output logic      [CNT_W-1:0] snapshot,
    output logic                  serial
);

    logic [CNT_W-1:0] count;   // Live count
    logic [CNT_W-1:0] shreg;   // Outgoing shift register
    logic             hit;     // Counted pulse this cycle

    assign hit = pulse & enable;

    // ------------------------------------------------------------
    // Accumulate, then restart after each sample
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (sample) begin
            // A pulse on the sample cycle opens the new window
            count <= {{(CNT_W-1){1'b0}}, hit};
        end else if (hit && count != {CNT_W{1'b1}}) begin
            // Saturate rather than wrap
            count <= count + 1'b1;
        end
    end

    // Snapshot taken when sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snapshot <= '0;
        end else if (sample) begin
            snapshot <= count;
        end
    end

    // ------------------------------------------------------------
    // Shift register, msb first; load wins over shift
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg <= '0;
        end else if (tm_load) begin
            shreg <= snapshot;
        end else if (tm_shift) begin
            shreg <= {shreg[CNT_W-2:0], 1'b0};
        end
    end

    assign serial = shreg[CNT_W-1];

endmodule : isq_accum

// ==== isq_pkg.sv ====
/*
 * Shared constants, field layouts and carrier types for the ion
 * spectrometer sequencer: register offsets, mode codes, step and slot
 * counts and the structs that group the sequencer's outputs.
 * Assumes a single 200 MHz clock domain and an APB register bus.
 */
package isq_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00; // Command bits
    localparam logic [7:0] ADDR_STATUS = 8'h04; // Live sequencer state
    localparam logic [7:0] ADDR_PRIM   = 8'h08; // Primary count snapshot
    localparam logic [7:0] ADDR_SECA   = 8'h0c; // Secondary A snapshot
    localparam logic [7:0] ADDR_SECB   = 8'h10; // Secondary B snapshot

    // ----------------------------------------------------------------
    // Control word fields
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_A  = 0;  // Mode-select command A
    localparam int CTRL_MODE_B  = 1;  // Mode-select command B
    localparam int CTRL_CAL_EN  = 2;  // Calibration-enable command
    localparam int CTRL_HV_EN   = 3;  // Multiplier high-voltage enable
    localparam int CTRL_HV_LSB  = 4;  // Two-bit level select
    localparam logic [5:0] CTRL_RESET = 6'h00; // All commands OFF

    // Multiplier high-voltage level codes
    localparam logic [1:0] HV_NOMINAL = 2'h0;
    localparam logic [1:0] HV_RAISED  = 2'h1;
    localparam logic [1:0] HV_LOWERED = 2'h2;

    // ----------------------------------------------------------------
    // Timing derived from the spacecraft sync pulses
    // ----------------------------------------------------------------
    localparam int         STEP_W      = 5;      // 32 retarding steps
    localparam logic [4:0] STEP_ZERO   = 5'h00;  // Zero-potential step
    localparam logic [4:0] STEP_LAST   = 5'h1f;
    localparam int         SLOT_SEC    = 2;      // One slot, seconds
    localparam int         AUTO_MODE_SEC  = 64;  // Each automatic mode
    localparam int         AUTO_CYCLE_SEC = 256; // Full automatic cycle
    localparam int         AUTO_W      = 7;      // Slot counter width, 128 slots per cycle
    localparam int         AUTO_IDX_LSB = 5;     // log2 of slots per mode
    localparam int         CAL_PERIOD_HR = 18;
    localparam int         CAL_PERIOD_SLOTS = CAL_PERIOD_HR * 3600 / SLOT_SEC;
    localparam logic [2:0] CAL_SEQ_LAST = 3'h7;  // Eight-slot sequence
    localparam int         CNT_W       = 16;     // Accumulator width

    // Fixed post-acceleration settings (low, middle, high)
    localparam logic [4:0] MASS_OXY = 5'h00;
    localparam logic [4:0] MASS_HEL = 5'h0f;
    localparam logic [4:0] MASS_HYD = 5'h1f;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OXY     = 3'b000,
        MODE_HEL     = 3'b001,
        MODE_HYD     = 3'b010,
        MODE_DENSITY = 3'b011,
        MODE_OXY_CAL = 3'b100,
        MODE_HEL_CAL = 3'b101,
        MODE_HYD_CAL = 3'b110,
        MODE_AUTO    = 3'b111
    } isq_mode_t;

    // Reference generator settings shared by all heads
    typedef struct packed {
        logic [4:0] retard_step;
        logic [4:0] mass_code;
    } isq_ref_t;

    // Detector settings
    typedef struct packed {
        logic       hv_on;
        logic [1:0] hv_level;
        logic [1:0] threshold;
    } isq_det_t;

    // Bi-level status lines
    typedef struct packed {
        logic [5:0] cmd_echo;
        logic [2:0] active_mode;
        logic [1:0] base_mode;
        logic [1:0] head_phase;
        logic [4:0] step;
        logic       cal_active;
    } isq_status_t;

endpackage : isq_pkg

// ==== isq_sequencer.sv ====
/*
 * Ion spectrometer sequencer: mode decode, reference stepping, head
 * rotation, accumulation and APB command/status access.
 * Assumes the data system supplies a one-cycle minor sync at the step
 * rate and a major sync coinciding with it at each slot start.
 */
// How it works
// - Mode is A, B, calibrate as bits
// - Retarding reference picked from 32 steps
// - Step through all 32 per slot
// - Modes 0-2 hold fixed mass setting
// - Mode 3 zero retard, sweep mass
// - Calibration steps threshold and high voltage
// - Auto runs modes 0-3, 64 s each
// - Auto launches calibration every 18 hours
// - Head timing independent of mode
// - One reference set drives all heads
// - Primary sampled per step, secondaries per slot
// - Primary head order 1,2,1,3
// - Slot aligned to one full sequence
// - Secondaries count only at zero step
// - Counts go accumulator then shift register
// - High voltage off until own enable
// - Level nominal by default, raise or lower
// - All cycling derived from spacecraft sync
// - Status lines show commands, mode, position
`timescale 1ns/1ps
module isq_sequencer
    import isq_pkg::*;
#(
    parameter int CAL_PERIOD = CAL_PERIOD_SLOTS // Slots between auto cals
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Spacecraft sync
    input  wire logic        minor_sync,
    input  wire logic        major_sync,
    // Head pulses: side, forward, aft
    input  wire logic [2:0]  head_pulse,
    // Telemetry readout
    input  wire logic        tm_load,
    input  wire logic        tm_shift,
    output logic [2:0]       tm_data,
    // Analog references, detector, status
    output isq_ref_t         ref_out,
    output isq_det_t         det_out,
    output logic [1:0]       primary_head,
    output isq_status_t      status
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [5:0]        ctrl;          // Command word
    isq_mode_t         active_mode;   // Mode latched at slot start
    logic [STEP_W-1:0] step;          // Retarding step index
    logic [1:0]        head_phase;    // Position in 1-2-1-3
    logic [AUTO_W-1:0] auto_slot;     // Slot within automatic cycle
    logic [15:0]       cal_timer;     // Slots since last auto cal
    logic              cal_run;       // Auto calibration in progress
    logic [2:0]        cal_step;      // Calibration sequence position
    logic              boundary;      // Last step of a slot ends
    logic [1:0]        base_mode;     // Measurement currently run
    logic              cal_active;    // Calibration stepping now
    logic [1:0]        prim_idx;      // Head index on primary
    logic              pulse_p;       // Routed head pulses
    logic              pulse_a;
    logic              pulse_b;
    logic              sec_en;        // Secondary counting window
    logic [CNT_W-1:0]  snap_p;        // Snapshots for readback
    logic [CNT_W-1:0]  snap_a;
    logic [CNT_W-1:0]  snap_b;
    logic [2:0]        ser;           // Serial bits from accumulators
    logic              apb_done;      // Access phase being answered
    logic [31:0]       next_rdata;
    logic              next_err;

    // ----------------------------------------------------------------
    // Slot timing from the sync pulses
    // ----------------------------------------------------------------
    // Major sync realigns so cycling tracks the vehicle time code
    assign boundary = minor_sync & (major_sync | step == STEP_LAST);

    // Step counter advances on each sample pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step <= STEP_ZERO;
        end else if (minor_sync) begin
            step <= boundary ? STEP_ZERO : step + 1'b1;
        end
    end

    // Mode taken only at slot start so no sweep is cut short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_mode <= MODE_OXY;
        end else if (boundary) begin
            active_mode <= isq_mode_t'(ctrl[CTRL_CAL_EN:CTRL_MODE_A]);
        end
    end

    // Head rotation ignores mode entirely
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_phase <= 2'h0;
        end else if (boundary) begin
            head_phase <= head_phase + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Automatic cycle and calibration sequencing
    // ----------------------------------------------------------------
    // Slot counter wraps after the full automatic cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_slot <= '0;
        end else if (boundary) begin
            if (active_mode == MODE_AUTO) begin
                auto_slot <= auto_slot + 1'b1;
            end else begin
                auto_slot <= '0;
            end
        end
    end

    // Long period timer for automatic calibration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_timer <= '0;
            cal_run   <= 1'b0;
        end else if (boundary) begin
            if (active_mode != MODE_AUTO) begin
                // Leaving automatic drops any pending calibration
                cal_timer <= '0;
                cal_run   <= 1'b0;
            end else if (cal_timer == 16'(CAL_PERIOD - 1)) begin
                cal_timer <= '0;
                cal_run   <= 1'b1;
            end else begin
                cal_timer <= cal_timer + 1'b1;
                if (cal_run && cal_step == CAL_SEQ_LAST) begin
                    cal_run <= 1'b0;
                end
            end
        end
    end

    // Calibration position moves one per slot while active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_step <= 3'h0;
        end else if (boundary) begin
            cal_step <= cal_active ? cal_step + 1'b1 : 3'h0;
        end
    end

    // Automatic walks modes 0..3 in order, 32 slots each
    always_comb begin
        if (active_mode == MODE_AUTO) begin
            base_mode = auto_slot[AUTO_W-1:AUTO_IDX_LSB];
        end else begin
            base_mode = active_mode[1:0];
        end
    end

    // Modes 4-6 calibrate continuously, automatic only on its timer
    assign cal_active = (active_mode[2] && active_mode != MODE_AUTO) || cal_run;

    // ----------------------------------------------------------------
    // Common reference generator outputs
    // ----------------------------------------------------------------
    // A single set feeds every head
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_out <= '0;
        end else begin
            unique case (base_mode)
                2'h0: ref_out <= '{retard_step: step, mass_code: MASS_OXY};
                2'h1: ref_out <= '{retard_step: step, mass_code: MASS_HEL};
                2'h2: ref_out <= '{retard_step: step, mass_code: MASS_HYD};
                2'h3: ref_out <= '{retard_step: STEP_ZERO, mass_code: step};
            endcase
        end
    end

    // Detector threshold and multiplier level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_out <= '{hv_on: 1'b0, hv_level: HV_NOMINAL, threshold: 2'h0};
        end else begin
            det_out.hv_on <= ctrl[CTRL_HV_EN];
            if (cal_active) begin
                // Four thresholds at raised, then four at lowered
                det_out.threshold <= cal_step[1:0];
                det_out.hv_level  <= cal_step[2] ? HV_LOWERED : HV_RAISED;
            end else begin
                det_out.threshold <= 2'h0;
                det_out.hv_level  <= ctrl[CTRL_HV_LSB +: 2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Head routing and accumulators
    // ----------------------------------------------------------------
    // Even phases side head, odd phases forward then aft
    assign prim_idx = head_phase[0] ? (head_phase[1] ? 2'h2 : 2'h1) : 2'h0;
    assign pulse_p  = head_pulse[prim_idx];
    assign pulse_a  = (prim_idx == 2'h0) ? head_pulse[1] : head_pulse[0];
    assign pulse_b  = (prim_idx == 2'h2) ? head_pulse[1] : head_pulse[2];
    assign sec_en   = (step == STEP_ZERO);

    // Primary is sampled every step
    isq_accum u_prim (
        .pclk     (pclk),
        .presetn  (presetn),
        .pulse    (pulse_p),
        .enable   (1'b1),
        .sample   (minor_sync),
        .tm_load  (tm_load),
        .tm_shift (tm_shift),
        .snapshot (snap_p),
        .serial   (ser[0])
    );

    // Secondaries are sampled once per slot
    isq_accum u_seca (
        .pclk     (pclk),
        .presetn  (presetn),
        .pulse    (pulse_a),
        .enable   (sec_en),
        .sample   (boundary),
        .tm_load  (tm_load),
        .tm_shift (tm_shift),
        .snapshot (snap_a),
        .serial   (ser[1])
    );

    isq_accum u_secb (
        .pclk     (pclk),
        .presetn  (presetn),
        .pulse    (pulse_b),
        .enable   (sec_en),
        .sample   (boundary),
        .tm_load  (tm_load),
        .tm_shift (tm_shift),
        .snapshot (snap_b),
        .serial   (ser[2])
    );

    // Serial bits and head index re-timed onto output flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tm_data      <= 3'h0;
            primary_head <= 2'h0;
        end else begin
            tm_data      <= ser;
            primary_head <= prim_idx;
        end
    end

    // Bi-level status lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else begin
            status <= '{cmd_echo: ctrl, active_mode: active_mode, base_mode: base_mode,
                        head_phase: head_phase, step: step,
                        cal_active: cal_active};
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Answer on the second access cycle; write lands with pready
    assign apb_done = psel & penable & pready;

    // Read mux, unmapped answers with an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        unique case (paddr)
            ADDR_CTRL:   next_rdata = {26'h0, ctrl};
            ADDR_STATUS: next_rdata = {13'h0, status};
            ADDR_PRIM:   next_rdata = {16'h0, snap_p};
            ADDR_SECA:   next_rdata = {16'h0, snap_a};
            ADDR_SECB:   next_rdata = {16'h0, snap_b};
            default:     next_err   = 1'b1;
        endcase
    end

    // Handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= psel & penable & ~pready & next_err;
        end
    end

    // Command word; other offsets ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (apb_done && pwrite && paddr == ADDR_CTRL) begin
            ctrl <= pwdata[5:0];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_slot_end;
        minor_sync && boundary;
    endsequence

    a_mode_latch: assert property (@(posedge pclk) disable iff (!presetn)
        s_slot_end |=> active_mode == $past(ctrl[2:0]))
        else $error("mode not taken at slot start");
    a_step_walk: assert property (@(posedge pclk) disable iff (!presetn)
        (minor_sync && !boundary) |=> step == $past(step) + 5'h01)
        else $error("step did not advance");
    a_density_ref: assert property (@(posedge pclk) disable iff (!presetn)
        (base_mode == 2'h3) |=> ref_out.retard_step == STEP_ZERO
                                && ref_out.mass_code == $past(step))
        else $error("density mode reference wrong");
    a_fixed_mass: assert property (@(posedge pclk) disable iff (!presetn)
        (base_mode == 2'h2) |=> ref_out.mass_code == MASS_HYD)
        else $error("hydrogen setting wrong");
    a_head_order: assert property (@(posedge pclk) disable iff (!presetn)
        s_slot_end |=> (prim_idx == 2'h0) != ($past(prim_idx) == 2'h0))
        else $error("head order broken");
    a_hv_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[CTRL_HV_EN] [*2] |-> !det_out.hv_on)
        else $error("high voltage on without enable");
    a_auto_order: assert property (@(posedge pclk) disable iff (!presetn)
        (active_mode == MODE_AUTO && auto_slot == 7'h1f && boundary)
        |=> base_mode == 2'h1 || active_mode != MODE_AUTO)
        else $error("automatic order wrong");
    a_sec_window: assert property (@(posedge pclk) disable iff (!presetn)
        (step != STEP_ZERO && !boundary) |=> $stable(u_seca.count))
        else $error("secondary counting off zero step");
    a_cal_level: assert property (@(posedge pclk) disable iff (!presetn)
        cal_active |=> det_out.hv_level != HV_NOMINAL)
        else $error("calibration left level nominal");
    a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("APB answer not one cycle");
endmodule : isq_sequencer

// ==== isq_sync_model.sv ====
/* Data system model: minor and major sync pulse source.
   Assumes the sequencer's pclk and presetn. */
`timescale 1ns/1ps
module isq_sync_model #(
    parameter int PER = 8 // Cycles per retarding step
)(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Sync pulses
    output logic      minor_sync,
    output logic      major_sync
);
    // ------------------------------------------------------------
    // Step and slot pacing
    // ------------------------------------------------------------
    int cyc; // Cycles into the step
    int stp; // Steps into the slot
    // Major rides on every 32nd minor so slots stay on the time code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc        <= 0;
            stp        <= 0;
            minor_sync <= 1'b0;
            major_sync <= 1'b0;
        end else begin
            cyc        <= (cyc == PER - 1) ? 0 : cyc + 1;
            minor_sync <= (cyc == PER - 1);
            major_sync <= (cyc == PER - 1) && (stp == 0);
            if (cyc == PER - 1) begin
                stp <= (stp == 31) ? 0 : stp + 1;
            end
        end
    end
endmodule : isq_sync_model
